// file: design/amp_params.svh
// register offsets, reset values, field positions and bus addresses of the amp control bank
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH

// register offsets on the control bus
`define AMP_OFS_STATUS 8'h00
`define AMP_OFS_CFG1 8'h01
`define AMP_OFS_CFG2 8'h02
`define AMP_OFS_CFG3 8'h03
`define AMP_OFS_IDLE 8'h04
`define AMP_OFS_FMT 8'h05
`define AMP_OFS_RSVD 8'h18
`define AMP_OFS_VBAT 8'h19

// reset values
`define AMP_RST_CFG1 8'h22
`define AMP_RST_CFG2 8'hEF
`define AMP_RST_CFG3 8'h80
`define AMP_RST_IDLE 8'h00
`define AMP_RST_FMT 8'h00

// bits that hold state; all other bits read as zero
`define AMP_MASK_CFG1 8'h36
`define AMP_MASK_CFG2 8'hEF
`define AMP_MASK_IDLE 8'h04

// status fields
`define AMP_B_UNLOCK 5
`define AMP_B_OVERCUR 1
`define AMP_B_THERMAL 0

// clock source and power control fields
`define AMP_F_PLLSRC 5:4
`define AMP_B_MUTE 2
`define AMP_B_SHUTDOWN 1
`define AMP_B_SRESET 0

// block enable fields
`define AMP_B_AMPEN 7
`define AMP_B_BOOSTEN 6
`define AMP_B_APTEN 5
`define AMP_B_PLLEN 3
`define AMP_B_LIMEN 2
`define AMP_B_SENSEEN 1

// input path and rate fields
`define AMP_B_ANALOG 7
`define AMP_B_FRAMED 6
`define AMP_B_PDMIN 5
`define AMP_F_SOURCE 4:3
`define AMP_F_RATE 2:0

// serial idle and format fields
`define AMP_B_IDLEHIZ 2
`define AMP_B_FCLKDIR 7
`define AMP_B_BIT_CLOCK_DIRECTION 6
`define AMP_F_CPF 5:4
`define AMP_F_FORMAT 3:2
`define AMP_F_WLEN 1:0

// control bus device addresses, chosen by the address select pin
`define AMP_I2C_ADDR0 7'h40
`define AMP_I2C_ADDR1 7'h41
`define AMP_BITS_PER_BYTE 4'h8

`endif

// file: design/amp_pkg.sv
// types shared by the amp control bank modules
package amp_pkg;
   // control bus byte engine states
   typedef enum logic [2:0] {
      I2C_IDLE, I2C_DEV, I2C_ACK, I2C_WRITE, I2C_READ, I2C_MACK
   } amp_i2c_state_type;
   // pll reference sources
   typedef enum logic [1:0] {
      PLL_FROM_MASTER_CLK, PLL_FROM_BIT_CLK, PLL_FROM_SENSE_CLK, PLL_FROM_INT_OSC
   } amp_pll_reference_select_type;
endpackage

// file: design/amp_regbus_if.sv
// internal register access carrier between the bus engine and the register bank
`timescale 1ns/1ns
interface amp_regbus_if;
   logic wr; // one-cycle write strobe
   logic [7:0] waddr; // write offset
   logic [7:0] wdata; // write byte
   logic [7:0] raddr; // read offset
   logic [7:0] rdata; // read byte, combinational
   logic [6:0] dev_addr; // our bus address
   modport master (output wr, waddr, wdata, raddr, input rdata, dev_addr);
   modport bank (input wr, waddr, wdata, raddr, output rdata, dev_addr);
endinterface

// file: design/amp_sync.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module amp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q; // first stage, read only by the second

   // both stages clear to zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// file: design/amp_i2c_slave.sv
// control bus byte engine: addressing, register pointer, writes and reads
`timescale 1ns/1ns
`include "amp_params.svh"
module amp_i2c_slave (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bus pins
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_oe,
   // register access
   amp_regbus_if.master bus
);
   import amp_pkg::*;

   logic [1:0] s; // synchronised {scl, sda}
   logic [1:0] s_n; // synchronised inverted levels, reset value matches the idle-high bus
   logic scl_p_q, sda_p_q; // previous synchronised levels
   logic rise, fall, start, stop; // bus events
   amp_i2c_state_type st_q, st_d; // byte engine state
   logic [3:0] bits_q, bits_d; // bits in the current byte
   logic [7:0] sh_q, sh_d; // shift register
   logic [7:0] ptr_q, ptr_d; // register pointer
   logic first_q, first_d; // next written byte is the pointer
   logic rw_q, rw_d; // read transfer
   logic oe_q, oe_d; // pull data line low
   logic wr_q, wr_d; // write strobe
   logic [7:0] wa_q, wa_d, wd_q, wd_d; // write offset and byte

   // pins pass inverted so the cleared synchroniser reads idle-high, no false edge after reset
   amp_sync #(.W(2)) u_pins (.clk(clk), .resetn(resetn), .din(~{scl, sda_i}), .dout(s_n));
   assign s = ~s_n;

   assign rise = s[1] & ~scl_p_q;
   assign fall = ~s[1] & scl_p_q;
   assign start = s[1] & scl_p_q & sda_p_q & ~s[0];
   assign stop = s[1] & scl_p_q & ~sda_p_q & s[0];
   assign sda_oe = oe_q;
   assign bus.wr = wr_q;
   assign bus.waddr = wa_q;
   assign bus.wdata = wd_q;
   assign bus.raddr = ptr_q;

   // next state of the byte engine
   always_comb begin
      st_d = st_q; bits_d = bits_q; sh_d = sh_q; ptr_d = ptr_q;
      first_d = first_q; rw_d = rw_q; oe_d = oe_q;
      wr_d = 1'b0; wa_d = wa_q; wd_d = wd_q;
      if (start) begin
         st_d = I2C_DEV; bits_d = 4'h0; oe_d = 1'b0;
      end else if (stop) begin
         st_d = I2C_IDLE; oe_d = 1'b0;
      end else if (rise) begin
         case (st_q)
            I2C_DEV, I2C_WRITE: begin // sample a bit
               sh_d = {sh_q[6:0], s[0]};
               bits_d = bits_q + 4'h1;
            end
            I2C_MACK: if (s[0]) st_d = I2C_IDLE; // master ends the read
            default: ;
         endcase
      end else if (fall) begin
         case (st_q)
            I2C_DEV: if (bits_q == `AMP_BITS_PER_BYTE) begin
               if (sh_q[7:1] == bus.dev_addr) begin
                  st_d = I2C_ACK; oe_d = 1'b1; rw_d = sh_q[0]; first_d = 1'b1;
               end else begin
                  st_d = I2C_IDLE;
               end
            end
            I2C_WRITE: if (bits_q == `AMP_BITS_PER_BYTE) begin
               st_d = I2C_ACK; oe_d = 1'b1;
               if (first_q) begin // pointer byte
                  ptr_d = sh_q; first_d = 1'b0;
               end else begin // data byte, pointer advances
                  wr_d = 1'b1; wa_d = ptr_q; wd_d = sh_q; ptr_d = ptr_q + 8'h01;
               end
            end
            I2C_ACK, I2C_MACK: if (st_q == I2C_ACK && !rw_q) begin
               st_d = I2C_WRITE; oe_d = 1'b0; bits_d = 4'h0;
            end else begin // load and drive the next read byte
               st_d = I2C_READ; sh_d = bus.rdata; oe_d = ~bus.rdata[7];
               bits_d = 4'h1; ptr_d = ptr_q + 8'h01;
            end
            I2C_READ: if (bits_q == `AMP_BITS_PER_BYTE) begin
               st_d = I2C_MACK; oe_d = 1'b0;
            end else begin
               sh_d = {sh_q[6:0], 1'b0}; oe_d = ~sh_q[6]; bits_d = bits_q + 4'h1;
            end
            default: ;
         endcase
      end
   end

   // engine registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= I2C_IDLE; bits_q <= 4'h0; sh_q <= 8'h00; ptr_q <= 8'h00;
         first_q <= 1'b0; rw_q <= 1'b0; oe_q <= 1'b0; wr_q <= 1'b0;
         wa_q <= 8'h00; wd_q <= 8'h00; scl_p_q <= 1'b1; sda_p_q <= 1'b1;
      end else begin
         st_q <= st_d; bits_q <= bits_d; sh_q <= sh_d; ptr_q <= ptr_d;
         first_q <= first_d; rw_q <= rw_d; oe_q <= oe_d; wr_q <= wr_d;
         wa_q <= wa_d; wd_q <= wd_d; scl_p_q <= s[1]; sda_p_q <= s[0];
      end
   end

   // a foreign address byte is never acknowledged
   property p_foreign_addr;
      @(posedge clk) disable iff (!resetn)
      (fall && !start && !stop && st_q == I2C_DEV && bits_q == `AMP_BITS_PER_BYTE
       && sh_q[7:1] != bus.dev_addr) |=> (st_q == I2C_IDLE && !sda_oe);
   endproperty
   a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked");
endmodule

// file: design/amp_control_register_bank.sv
// control and status register bank of the mono amplifier, reached over the control bus
`timescale 1ns/1ns
`include "amp_params.svh"
//
// Contract
// - fault bits latch; reads do not clear
// - status write clears latched fault bits
// - status bit 5 shows pll unlocked
// - bit 1 overcurrent, bit 0 thermal fault
// - bits 5-4 pick pll reference source
// - config 1 bit 2 mutes the amplifier
// - shutdown bit powers down all blocks
// - soft reset bit restores all reset values
// - config 2 holds per-block enables, default 1
// - config 3 bit 7 picks analog input
// - bit 6 picks framed sense output format
// - pdm input only with digital input
// - bits 4-3 choose modulator input source
// - bits 2-0 choose the frame rate
// - idle serial out: hi-z or low
// - bits 7/6 set frame/bit clock direction
// - bits 5-4 set clocks per frame
// - bits 3-2 set serial framing format
// - bits 1-0 set sample word length
// - bus address 0x40 or 0x41 by pin
module amp_control_register_bank (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // control bus pins
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic ADDR_SEL,
   // analog condition levels, asynchronous
   input wire logic PLL_LOCKED,
   input wire logic AMP_OVERCURRENT,
   input wire logic OVER_TEMPERATURE,
   // battery reading from the sense logic, same clock
   input wire logic [7:0] BATTERY_READING,
   // serial data output path, same clock
   input wire logic SERIAL_TX_ACTIVE,
   input wire logic SERIAL_TX_BIT,
   output logic SDOUT_O,
   output logic SDOUT_OE,
   // power and clocking controls
   output logic POWER_DOWN,
   output logic AMP_MUTE,
   output amp_pkg::amp_pll_reference_select_type PLL_REF_SELECT,
   // block enables
   output logic AMP_STAGE_ENABLE,
   output logic BOOST_ENABLE,
   output logic AUTO_PASSTHROUGH_ENABLE,
   output logic PLL_ENABLE,
   output logic GAIN_LIMITER_ENABLE,
   output logic LOAD_SENSE_ENABLE,
   // input path and rate
   output logic ANALOG_INPUT_SELECT,
   output logic SENSE_OUT_FRAMED,
   output logic PULSE_DENSITY_INPUT_SELECT,
   output logic [1:0] INPUT_SOURCE_SELECT,
   output logic [2:0] FRAME_RATE_SELECT,
   // serial port format
   output logic FRAME_CLOCK_DIRECTION,
   output logic BIT_CLOCK_DIRECTION,
   output logic [1:0] BIT_CLOCKS_PER_FRAME,
   output logic [1:0] SERIAL_FRAMING_FORMAT,
   output logic [1:0] SAMPLE_WORD_LENGTH
);
   import amp_pkg::*;

   amp_regbus_if bus (); // register access from the bus engine

   logic [3:0] sync_w; // synchronised {locked, overcurrent, thermal, addr pin}
   logic pll_locked_s; // pll lock level
   logic ovc_s; // overcurrent level
   logic therm_s; // thermal level
   logic addr_sel_s; // address select level

   logic [1:0] status_q, status_d; // latched {overcurrent, thermal}
   logic [7:0] cfg1_q, cfg1_d; // clock source and power control
   logic [7:0] cfg2_q, cfg2_d; // block enables
   logic [7:0] cfg3_q, cfg3_d; // input path and rate
   logic [7:0] idle_q, idle_d; // serial out idle control
   logic [7:0] fmt_q, fmt_d; // serial port format
   logic srst_q, srst_d; // soft reset pending
   logic sdout_o_q, sdout_o_d; // serial data pin level
   logic sdout_oe_q, sdout_oe_d; // serial data pin drive
   logic shut; // software shutdown active
   logic wr_status, wr_cfg1; // decoded writes used more than once

   // true for a write strobe at the given offset
   function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
      hit = wr && (a == ofs);
   endfunction

   // external levels pass two flip-flops first
   amp_sync #(.W(4)) u_sync (
      .clk(CLK),
      .resetn(RESETN),
      .din({PLL_LOCKED, AMP_OVERCURRENT, OVER_TEMPERATURE, ADDR_SEL}),
      .dout(sync_w)
   );
   assign pll_locked_s = sync_w[3];
   assign ovc_s = sync_w[2];
   assign therm_s = sync_w[1];
   assign addr_sel_s = sync_w[0];

   // bus engine; the data line is open drain so only its enable moves
   amp_i2c_slave u_i2c (
      .clk(CLK),
      .resetn(RESETN),
      .scl(SCL),
      .sda_i(SDA_I),
      .sda_oe(SDA_OE),
      .bus(bus.master)
   );
   assign SDA_O = 1'b0;

   // our bus address follows the select pin
   assign bus.dev_addr = addr_sel_s ? `AMP_I2C_ADDR1 : `AMP_I2C_ADDR0;

   assign wr_status = hit(bus.wr, bus.waddr, `AMP_OFS_STATUS);
   assign wr_cfg1 = hit(bus.wr, bus.waddr, `AMP_OFS_CFG1);

   // next register values
   always_comb begin
      status_d = status_q;
      cfg1_d = cfg1_q;
      cfg2_d = cfg2_q;
      cfg3_d = cfg3_q;
      idle_d = idle_q;
      fmt_d = fmt_q;
      srst_d = 1'b0;
      if (srst_q) begin
         // soft reset returns every register to its reset value
         status_d = 2'h0;
         cfg1_d = `AMP_RST_CFG1;
         cfg2_d = `AMP_RST_CFG2;
         cfg3_d = `AMP_RST_CFG3;
         idle_d = `AMP_RST_IDLE;
         fmt_d = `AMP_RST_FMT;
      end else begin
         // any write to status clears the latched faults
         if (wr_status) begin
            status_d = 2'h0;
         end
         // faults latch; a live fault wins over a clear in the same cycle
         status_d = status_d | {ovc_s, therm_s};
         if (wr_cfg1) begin
            cfg1_d = bus.wdata & `AMP_MASK_CFG1;
            srst_d = bus.wdata[`AMP_B_SRESET];
         end
         if (hit(bus.wr, bus.waddr, `AMP_OFS_CFG2)) begin
            cfg2_d = bus.wdata & `AMP_MASK_CFG2;
         end
         if (hit(bus.wr, bus.waddr, `AMP_OFS_CFG3)) begin
            cfg3_d = bus.wdata;
         end
         if (hit(bus.wr, bus.waddr, `AMP_OFS_IDLE)) begin
            idle_d = bus.wdata & `AMP_MASK_IDLE;
         end
         if (hit(bus.wr, bus.waddr, `AMP_OFS_FMT)) begin
            fmt_d = bus.wdata;
         end
      end
   end

   // register file
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         status_q <= 2'h0;
         cfg1_q <= `AMP_RST_CFG1;
         cfg2_q <= `AMP_RST_CFG2;
         cfg3_q <= `AMP_RST_CFG3;
         idle_q <= `AMP_RST_IDLE;
         fmt_q <= `AMP_RST_FMT;
         srst_q <= 1'b0;
      end else begin
         status_q <= status_d;
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
         cfg3_q <= cfg3_d;
         idle_q <= idle_d;
         fmt_q <= fmt_d;
         srst_q <= srst_d;
      end
   end

   // read data; reads have no side effect
   always_comb begin
      case (bus.raddr)
         `AMP_OFS_STATUS: begin
            bus.rdata = 8'h00;
            bus.rdata[`AMP_B_UNLOCK] = ~pll_locked_s;
            bus.rdata[`AMP_B_OVERCUR] = status_q[1];
            bus.rdata[`AMP_B_THERMAL] = status_q[0];
         end
         `AMP_OFS_CFG1: bus.rdata = cfg1_q; // soft reset bit reads zero
         `AMP_OFS_CFG2: bus.rdata = cfg2_q;
         `AMP_OFS_CFG3: bus.rdata = cfg3_q;
         `AMP_OFS_IDLE: bus.rdata = idle_q;
         `AMP_OFS_FMT: bus.rdata = fmt_q;
         `AMP_OFS_VBAT: bus.rdata = BATTERY_READING;
         default: bus.rdata = 8'h00; // reserved and unmapped offsets
      endcase
   end

   // serial data pin: data while sending, else low or released
   always_comb begin
      if (SERIAL_TX_ACTIVE) begin
         sdout_o_d = SERIAL_TX_BIT;
         sdout_oe_d = 1'b1;
      end else begin
         sdout_o_d = 1'b0;
         sdout_oe_d = ~idle_q[`AMP_B_IDLEHIZ];
      end
   end

   // serial data pin registers
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sdout_o_q <= 1'b0;
         sdout_oe_q <= 1'b0;
      end else begin
         sdout_o_q <= sdout_o_d;
         sdout_oe_q <= sdout_oe_d;
      end
   end
   assign SDOUT_O = sdout_o_q;
   assign SDOUT_OE = sdout_oe_q;

   // shutdown forces every block off
   assign shut = cfg1_q[`AMP_B_SHUTDOWN];
   assign POWER_DOWN = shut;
   assign AMP_MUTE = cfg1_q[`AMP_B_MUTE];
   assign PLL_REF_SELECT = amp_pll_reference_select_type'(cfg1_q[`AMP_F_PLLSRC]);
   assign AMP_STAGE_ENABLE = cfg2_q[`AMP_B_AMPEN] & ~shut;
   assign BOOST_ENABLE = cfg2_q[`AMP_B_BOOSTEN] & ~shut;
   assign AUTO_PASSTHROUGH_ENABLE = cfg2_q[`AMP_B_APTEN] & ~shut;
   assign PLL_ENABLE = cfg2_q[`AMP_B_PLLEN] & ~shut;
   assign GAIN_LIMITER_ENABLE = cfg2_q[`AMP_B_LIMEN] & ~shut;
   assign LOAD_SENSE_ENABLE = cfg2_q[`AMP_B_SENSEEN] & ~shut;

   // input path: pdm input counts only with digital input selected
   assign ANALOG_INPUT_SELECT = cfg3_q[`AMP_B_ANALOG];
   assign SENSE_OUT_FRAMED = cfg3_q[`AMP_B_FRAMED];
   assign PULSE_DENSITY_INPUT_SELECT = cfg3_q[`AMP_B_PDMIN] & ~cfg3_q[`AMP_B_ANALOG];
   assign INPUT_SOURCE_SELECT = cfg3_q[`AMP_F_SOURCE];
   assign FRAME_RATE_SELECT = cfg3_q[`AMP_F_RATE];

   // serial port format fields
   assign FRAME_CLOCK_DIRECTION = fmt_q[`AMP_B_FCLKDIR];
   assign BIT_CLOCK_DIRECTION = fmt_q[`AMP_B_BIT_CLOCK_DIRECTION];
   assign BIT_CLOCKS_PER_FRAME = fmt_q[`AMP_F_CPF];
   assign SERIAL_FRAMING_FORMAT = fmt_q[`AMP_F_FORMAT];
   assign SAMPLE_WORD_LENGTH = fmt_q[`AMP_F_WLEN];

   // a live fault is latched one edge later
   property p_fault_latch;
      @(posedge CLK) disable iff (!RESETN)
      (ovc_s && !srst_q) |=> status_q[1];
   endproperty
   a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");

   // a latched fault stays until a status write or soft reset
   property p_fault_hold;
      @(posedge CLK) disable iff (!RESETN)
      (status_q[0] && !wr_status && !srst_q) |=> status_q[0];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault lost without write");

   // a status write clears a fault that has gone away
   property p_fault_clear;
      @(posedge CLK) disable iff (!RESETN)
      (wr_status && !therm_s && !srst_q) |=> !status_q[0];
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

   // a persistent fault survives a clear written while it is present
   property p_fault_reassert;
      @(posedge CLK) disable iff (!RESETN)
      (wr_status && ovc_s && !srst_q) |=> status_q[1];
   endproperty
   a_fault_reassert: assert property (p_fault_reassert) else $error("fault dropped");

   // unlock bit reads the inverse of lock
   property p_unlock_read;
      @(posedge CLK) disable iff (!RESETN)
      (bus.raddr == `AMP_OFS_STATUS) |-> (bus.rdata[`AMP_B_UNLOCK] != pll_locked_s);
   endproperty
   a_unlock_read: assert property (p_unlock_read) else $error("unlock bit wrong");

   // shutdown holds the amp stage, boost, pll and load sense enables low
   property p_shutdown;
      @(posedge CLK) disable iff (!RESETN)
      POWER_DOWN |-> !(AMP_STAGE_ENABLE || BOOST_ENABLE || PLL_ENABLE || LOAD_SENSE_ENABLE);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("block on in shutdown");

   // soft reset restores reset values two edges after the write
   property p_soft_reset;
      @(posedge CLK) disable iff (!RESETN)
      (wr_cfg1 && bus.wdata[`AMP_B_SRESET] && !srst_q) |=> srst_q ##1
      (cfg1_q == `AMP_RST_CFG1 && cfg2_q == `AMP_RST_CFG2 && fmt_q == `AMP_RST_FMT);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

   // pdm input never selected with analog input
   property p_pdm_gate;
      @(posedge CLK) disable iff (!RESETN)
      ANALOG_INPUT_SELECT |-> !PULSE_DENSITY_INPUT_SELECT;
   endproperty
   a_pdm_gate: assert property (p_pdm_gate) else $error("pdm with analog input");

   // idle serial output released when hi-z is chosen
   property p_idle_hiz;
      @(posedge CLK) disable iff (!RESETN)
      (!SERIAL_TX_ACTIVE && idle_q[`AMP_B_IDLEHIZ]) |=> !SDOUT_OE;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("idle out not released");

   // idle serial output driven low otherwise
   property p_idle_low;
      @(posedge CLK) disable iff (!RESETN)
      (!SERIAL_TX_ACTIVE && !idle_q[`AMP_B_IDLEHIZ]) |=> (SDOUT_OE && !SDOUT_O);
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("idle out not low");

   // a format write lands on the format outputs
   property p_fmt_store;
      @(posedge CLK) disable iff (!RESETN)
      (hit(bus.wr, bus.waddr, `AMP_OFS_FMT) && !srst_q) |=>
      ({FRAME_CLOCK_DIRECTION, BIT_CLOCK_DIRECTION, BIT_CLOCKS_PER_FRAME,
        SERIAL_FRAMING_FORMAT, SAMPLE_WORD_LENGTH} == $past(bus.wdata));
   endproperty
   a_fmt_store: assert property (p_fmt_store) else $error("format not stored");

   // main scenarios
   c_fault: cover property (@(posedge CLK) disable iff (!RESETN) $rose(status_q[1]));
   c_clear: cover property (@(posedge CLK) disable iff (!RESETN) wr_status ##1 !status_q[0]);
   c_srst: cover property (@(posedge CLK) disable iff (!RESETN) srst_q);
   c_wake: cover property (@(posedge CLK) disable iff (!RESETN) $fell(POWER_DOWN));
endmodule

// file: verif/amp_host_model.sv
// host model that masters the control bus
`timescale 1ns/1ns
module amp_host_model (
   // clock
   input wire logic clk,
   // bus lines
   input wire logic dev_pull,
   output logic scl,
   output logic sda
);
   logic low_q; // host pulls data low
   // open drain data line with pull-up
   assign sda = !(low_q || dev_pull);
   initial begin
      scl = 1'b1;
      low_q = 1'b0;
   end
   // wait n edges, then step just past the edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // start or repeated start: data falls while clock is high
   task automatic go();
      low_q = 1'b0;
      wt(6);
      scl = 1'b1;
      wt(6);
      low_q = 1'b1;
      wt(6);
      scl = 1'b0;
   endtask
   // stop: data rises while clock is high
   task automatic halt();
      wt(6);
      low_q = 1'b1;
      wt(6);
      scl = 1'b1;
      wt(6);
      low_q = 1'b0;
      wt(6);
   endtask
   // eight bits and the acknowledge slot, msb first, data held well past clock edges
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         low_q = !d[i];
         wt(6);
         scl = 1'b1;
         wt(4);
         r[i] = sda;
         wt(4);
         scl = 1'b0;
         wt(5);
      end
   endtask
   // write: address, pointer, one byte; nack set if any slot went unanswered
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
         output logic nack);
      logic [8:0] r0, r1, r2;
      go();
      xfer({a, 2'b01}, r0);
      xfer({p, 1'b1}, r1);
      xfer({v, 1'b1}, r2);
      halt();
      nack = r0[0] | r1[0] | r2[0];
   endtask
   // read: pointer, repeated start, one byte closed by nack
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] v);
      logic [8:0] r;
      go();
      xfer({a, 2'b01}, r);
      xfer({p, 1'b1}, r);
      go();
      xfer({a, 2'b11}, r);
      xfer(9'h1FF, r);
      halt();
      v = r[8:1];
   endtask
endmodule

// file: verif/amp_control_register_bank_bench.sv
// self-checking bench of the amp control register bank
`timescale 1ns/1ns
module amp_control_register_bank_bench;
   import amp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, lock = 1'b1, ocur = 1'b0, otemp = 1'b0, asel = 1'b0;
   logic tx_act = 1'b0, tx_bit = 1'b0, scl, sda, sda_oe, so, so_oe, pd, mute, amp_en, boost_en;
   logic pdm, nk, sda_o, ana, frm, fcd, bcd, apt, plle, lim, lse;
   logic [7:0] bat = 8'h5A, rv;
   logic [1:0] src, cpf, fmt, wl;
   logic [2:0] rate;
   amp_pll_reference_select_type pll;
   int n_errors = 0, checks_done = 0;
   // 20 MHz clock
   always #25 clk = !clk;
   amp_host_model i_host (.clk(clk), .dev_pull(sda_oe & !sda_o), .scl(scl), .sda(sda));
   amp_control_register_bank i_dut (.CLK(clk), .RESETN(rst_n), .SCL(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(asel), .PLL_LOCKED(lock), .AMP_OVERCURRENT(ocur),
      .OVER_TEMPERATURE(otemp), .BATTERY_READING(bat), .SERIAL_TX_ACTIVE(tx_act),
      .SERIAL_TX_BIT(tx_bit), .SDOUT_O(so), .SDOUT_OE(so_oe), .POWER_DOWN(pd), .AMP_MUTE(mute),
      .PLL_REF_SELECT(pll), .AMP_STAGE_ENABLE(amp_en), .BOOST_ENABLE(boost_en),
      .AUTO_PASSTHROUGH_ENABLE(apt), .PLL_ENABLE(plle), .GAIN_LIMITER_ENABLE(lim),
      .LOAD_SENSE_ENABLE(lse), .ANALOG_INPUT_SELECT(ana), .SENSE_OUT_FRAMED(frm),
      .PULSE_DENSITY_INPUT_SELECT(pdm),
      .INPUT_SOURCE_SELECT(src), .FRAME_RATE_SELECT(rate), .FRAME_CLOCK_DIRECTION(fcd),
      .BIT_CLOCK_DIRECTION(bcd), .BIT_CLOCKS_PER_FRAME(cpf), .SERIAL_FRAMING_FORMAT(fmt),
      .SAMPLE_WORD_LENGTH(wl));
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read a register and compare
   task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
      i_host.rd(7'h40, p, rv);
      chk(rv, exp);
   endtask
   // write a register, every slot must be acknowledged
   task automatic w(input logic [7:0] p, input logic [7:0] v);
      i_host.wr(7'h40, p, v, nk);
      chk({7'h00, nk}, 8'h00);
   endtask
   // reset levels at the pins and in the registers
   task automatic t_reset();
      chk({ana, frm, fcd, bcd, pd, mute, amp_en, boost_en}, 8'h88);
      chk({apt, plle, lim, lse, 2'h0, pll}, 8'h02);
      rchk(8'h00, 8'h00);
      rchk(8'h01, 8'h22);
      rchk(8'h02, 8'hEF);
      rchk(8'h03, 8'h80);
      rchk(8'h04, 8'h00);
      rchk(8'h05, 8'h00);
   endtask
   // every rate, source and serial format code
   task automatic t_codes();
      for (int i = 0; i < 8; i++) begin
         w(8'h03, {3'h3, i[1:0], i[2:0]});
         chk({ana, frm, pdm, src, rate}, {3'h3, i[1:0], i[2:0]});
      end
      w(8'h03, 8'hA0);
      chk({ana, frm, 5'h00, pdm}, 8'h80);
      for (int i = 0; i < 4; i++) begin
         w(8'h05, {4{i[1:0]}});
         chk({fcd, bcd, cpf, fmt, wl}, {4{i[1:0]}});
         rchk(8'h05, {4{i[1:0]}});
      end
   endtask
   // configure first, then enter shutdown; enables follow shutdown
   task automatic t_power();
      w(8'h02, 8'hA6);
      w(8'h01, 8'h34);
      chk({apt, plle, lim, lse, pd, mute, amp_en, boost_en}, 8'hB6);
      chk({6'h00, pll}, 8'h03);
      w(8'h01, 8'h02);
      chk({apt, plle, lim, lse, pd, mute, amp_en, boost_en}, 8'h08);
   endtask
   // latched faults, clear on write, live lock flag, persisting fault
   task automatic t_status();
      otemp = 1'b1;
      i_host.wt(8);
      otemp = 1'b0;
      rchk(8'h00, 8'h01);
      rchk(8'h00, 8'h01);
      w(8'h00, 8'h00);
      rchk(8'h00, 8'h00);
      ocur = 1'b1;
      i_host.wt(8);
      w(8'h00, 8'h00);
      rchk(8'h00, 8'h02);
      ocur = 1'b0;
      w(8'h00, 8'h00);
      lock = 1'b0;
      rchk(8'h00, 8'h20);
      lock = 1'b1;
      rchk(8'h00, 8'h00);
   endtask
   // soft reset restores reset values
   task automatic t_sreset();
      w(8'h01, 8'h03);
      i_host.wt(20000);
      rchk(8'h01, 8'h22);
      rchk(8'h05, 8'h00);
   endtask
   // address pin, reserved and read-only places
   task automatic t_addr();
      asel = 1'b1;
      i_host.wr(7'h40, 8'h04, 8'h04, nk);
      chk({7'h00, nk}, 8'h01);
      i_host.wr(7'h41, 8'h04, 8'h04, nk);
      chk({7'h00, nk}, 8'h00);
      asel = 1'b0;
      rchk(8'h04, 8'h04);
      w(8'h18, 8'hFF);
      rchk(8'h18, 8'h00);
      rchk(8'h19, 8'h5A);
   endtask
   // serial out idle level, then a bit in flight
   task automatic t_sdout();
      chk({6'h00, so_oe, so}, 8'h00);
      w(8'h04, 8'h00);
      chk({6'h00, so_oe, so}, 8'h02);
      tx_act = 1'b1;
      tx_bit = 1'b1;
      i_host.wt(3);
      chk({6'h00, so_oe, so}, 8'h03);
      tx_act = 1'b0;
   endtask
   // counts, verdict and end of run
   task automatic conclude();
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      i_host.wt(20000);
      t_reset();
      t_codes();
      t_power();
      t_status();
      t_sreset();
      t_addr();
      t_sdout();
      conclude();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule
